// ===== common/lowspeed_pkg.sv
// shared constants and types for the low-speed control block
package lowspeed_pkg;

   // timing, clock period in ps
   localparam int CLK_PERIOD_PS = 8000;
   localparam int RESET_MIN_NS  = 1000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int INIT_TIME_NS  = 2000;
   localparam int INIT_CYC      = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W         = 8;

   // serial bus address
   localparam logic [6:0] DEV_ADDR = 7'h50;

   // register indices
   localparam logic [1:0] REG_STATUS  = 2'h0;
   localparam logic [1:0] REG_FLAGS   = 2'h1;
   localparam logic [1:0] REG_CONTROL = 2'h2;
   localparam logic [1:0] REG_IDENT   = 2'h3;

   // field positions and reset values
   localparam int STAT_DNR_BIT = 0;
   localparam int STAT_LPM_BIT = 1;
   localparam int CTRL_LPM_BIT = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // arbitrary identification value
   localparam logic [7:0] IDENT_VALUE   = 8'h5A;

   typedef struct packed
   {
      logic fault;
      logic init_done;
   } event_flags_t;

   typedef enum logic [0:0]
   {
      INIT_RUN   = 1'b0,
      INIT_READY = 1'b1
   } init_state_t;

   typedef enum logic [2:0]
   {
      BUS_IDLE     = 3'b000,
      BUS_ADDR     = 3'b001,
      BUS_ADDR_ACK = 3'b010,
      BUS_WR_BYTE  = 3'b011,
      BUS_WR_ACK   = 3'b100,
      BUS_RD_BYTE  = 3'b101,
      BUS_RD_ACK   = 3'b110
   } bus_state_t;

endpackage : lowspeed_pkg

// ===== design/lowspeed_ctrl.sv
// low-speed control pins and 2-wire serial slave of a pluggable module
`timescale 1ns/1ps

module lowspeed_ctrl
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // host control pins
   input  wire logic module_select_n,
   input  wire logic module_reset_n,
   input  wire logic low_power_select,
   // 2-wire serial bus
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // open-drain status pins
   output logic      presence_detect_n_out,
   output logic      presence_detect_n_oe,
   output logic      attention_irq_n_out,
   output logic      attention_irq_n_oe,
   // module internals
   input  wire logic fault_event,
   output logic      power_cap,
   output logic      data_not_ready
);

   ////////////////////////////////////////////////////////////////////////////////
   // initialization sequencer

   localparam logic [lowspeed_pkg::CNT_W-1:0] HOLD_MAX =
      lowspeed_pkg::CNT_W'(lowspeed_pkg::RESET_MIN_CYC);
   localparam logic [lowspeed_pkg::CNT_W-1:0] INIT_LAST =
      lowspeed_pkg::CNT_W'(lowspeed_pkg::INIT_CYC - 1);

   lowspeed_pkg::init_state_t          init_state_reg, init_state_next;
   logic [lowspeed_pkg::CNT_W-1:0]     init_cnt_reg, init_cnt_next;
   logic [lowspeed_pkg::CNT_W-1:0]     hold_cnt_reg, hold_cnt_next;
   logic                               soft_rst;
   logic                               held;
   logic                               init_done_evt;

   always_comb
   begin
      init_state_next = init_state_reg;
      init_cnt_next   = init_cnt_reg;
      hold_cnt_next   = hold_cnt_reg;
      if (module_reset_n)
         hold_cnt_next = 8'h00;
      else if (hold_cnt_reg != HOLD_MAX)
         hold_cnt_next = hold_cnt_reg + 8'h01;
      // short pulses never reach the trigger
      soft_rst      = !module_reset_n && (hold_cnt_reg == HOLD_MAX - 8'h01);
      held          = (hold_cnt_reg == HOLD_MAX);
      // a module reset landing on the last count must not be swallowed by completion
      init_done_evt = (init_state_reg == lowspeed_pkg::INIT_RUN) && !held && !soft_rst
                      && (init_cnt_reg == INIT_LAST);
      unique case (init_state_reg)
         lowspeed_pkg::INIT_RUN:
         begin
            if (held)
               init_cnt_next = 8'h00;
            else if (init_done_evt)
            begin
               init_state_next = lowspeed_pkg::INIT_READY;
               init_cnt_next   = 8'h00;
            end
            else
               init_cnt_next = init_cnt_reg + 8'h01;
         end
         lowspeed_pkg::INIT_READY:
         begin
            if (soft_rst)
            begin
               init_state_next = lowspeed_pkg::INIT_RUN;
               init_cnt_next   = 8'h00;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         // power-up starts in the run state so completion is posted unaided
         init_state_reg <= lowspeed_pkg::INIT_RUN;
         init_cnt_reg   <= 8'h00;
         hold_cnt_reg   <= 8'h00;
      end
      else
      begin
         init_state_reg <= init_state_next;
         init_cnt_reg   <= init_cnt_next;
         hold_cnt_reg   <= hold_cnt_next;
      end
   end

   // host must not trust status while this is set
   assign data_not_ready = (init_state_reg == lowspeed_pkg::INIT_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // serial slave, register map and pins

   lowspeed_pkg::bus_state_t  bus_state_reg, bus_state_next;
   lowspeed_pkg::event_flags_t flags_reg, flags_next, clr_mask;
   logic [3:0]  bit_cnt_reg, bit_cnt_next;
   logic [7:0]  shreg_reg, shreg_next;
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [1:0]  ptr_reg, ptr_next;
   logic        have_ptr_reg, have_ptr_next;
   logic        is_read_reg, is_read_next;
   logic        sda_oe_reg, sda_oe_next;
   logic        scl_q_reg, sda_q_reg;
   logic        power_cap_reg, irq_oe_reg;
   logic        scl_rise, scl_fall, start_cond, stop_cond;
   logic        rd_load;
   logic [7:0]  rd_byte;

   function automatic logic [7:0] reg_read
   (
      input logic [1:0]                 idx,
      input lowspeed_pkg::event_flags_t flags,
      input logic [7:0]                 ctrl,
      input logic                       dnr,
      input logic                       cap
   );
      logic [7:0] val;
      val = 8'h00;
      unique case (idx)
         lowspeed_pkg::REG_STATUS:
         begin
            val[lowspeed_pkg::STAT_DNR_BIT] = dnr;
            val[lowspeed_pkg::STAT_LPM_BIT] = cap;
         end
         lowspeed_pkg::REG_FLAGS:   val = {6'h00, flags};
         lowspeed_pkg::REG_CONTROL: val = ctrl;
         lowspeed_pkg::REG_IDENT:   val = lowspeed_pkg::IDENT_VALUE;
      endcase
      return val;
   endfunction : reg_read

   always_comb
   begin
      bus_state_next = bus_state_reg;
      bit_cnt_next   = bit_cnt_reg;
      shreg_next     = shreg_reg;
      ctrl_next      = ctrl_reg;
      ptr_next       = ptr_reg;
      have_ptr_next  = have_ptr_reg;
      is_read_next   = is_read_reg;
      sda_oe_next    = sda_oe_reg;
      rd_load        = 1'b0;
      rd_byte        = reg_read(ptr_reg, flags_reg, ctrl_reg, data_not_ready, power_cap_reg);
      scl_rise       = scl_in && !scl_q_reg;
      scl_fall       = !scl_in && scl_q_reg;
      start_cond     = scl_in && scl_q_reg && sda_q_reg && !sda_in;
      stop_cond      = scl_in && scl_q_reg && !sda_q_reg && sda_in;
      if (soft_rst || module_select_n)
      begin
         // deselected or reset: release the bus and drop any transfer
         bus_state_next = lowspeed_pkg::BUS_IDLE;
         sda_oe_next    = 1'b0;
         if (soft_rst)
         begin
            ctrl_next = lowspeed_pkg::CONTROL_RESET;
            ptr_next  = 2'h0;
         end
      end
      else if (start_cond)
      begin
         bus_state_next = lowspeed_pkg::BUS_ADDR;
         bit_cnt_next   = 4'h0;
         sda_oe_next    = 1'b0;
      end
      else if (stop_cond)
      begin
         bus_state_next = lowspeed_pkg::BUS_IDLE;
         sda_oe_next    = 1'b0;
      end
      else
      begin
         unique case (bus_state_reg)
            lowspeed_pkg::BUS_IDLE: ;
            lowspeed_pkg::BUS_ADDR, lowspeed_pkg::BUS_WR_BYTE:
            begin
               if (scl_rise)
               begin
                  shreg_next   = {shreg_reg[6:0], sda_in};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end
               else if (scl_fall && bit_cnt_reg == 4'h8)
               begin
                  bit_cnt_next = 4'h0;
                  if (bus_state_reg == lowspeed_pkg::BUS_WR_BYTE)
                  begin
                     bus_state_next = lowspeed_pkg::BUS_WR_ACK;
                     sda_oe_next    = 1'b1;
                     have_ptr_next  = 1'b1;
                     if (!have_ptr_reg)
                        ptr_next = shreg_reg[1:0];
                     else
                     begin
                        if (ptr_reg == lowspeed_pkg::REG_CONTROL)
                           ctrl_next = shreg_reg;
                        ptr_next = ptr_reg + 2'h1;
                     end
                  end
                  else if (shreg_reg[7:1] == lowspeed_pkg::DEV_ADDR)
                  begin
                     bus_state_next = lowspeed_pkg::BUS_ADDR_ACK;
                     is_read_next   = shreg_reg[0];
                     sda_oe_next    = 1'b1;
                  end
                  else
                     bus_state_next = lowspeed_pkg::BUS_IDLE;
               end
            end
            lowspeed_pkg::BUS_ADDR_ACK, lowspeed_pkg::BUS_WR_ACK, lowspeed_pkg::BUS_RD_ACK:
            begin
               if (scl_rise && bus_state_reg == lowspeed_pkg::BUS_RD_ACK)
               begin
                  if (sda_in)
                     bus_state_next = lowspeed_pkg::BUS_IDLE;
                  else
                     bit_cnt_next = 4'h1;
               end
               else if (scl_fall)
               begin
                  sda_oe_next  = 1'b0;
                  bit_cnt_next = 4'h0;
                  if (bus_state_reg == lowspeed_pkg::BUS_ADDR_ACK && !is_read_reg)
                  begin
                     bus_state_next = lowspeed_pkg::BUS_WR_BYTE;
                     have_ptr_next  = 1'b0;
                  end
                  else if (bus_state_reg == lowspeed_pkg::BUS_WR_ACK)
                     bus_state_next = lowspeed_pkg::BUS_WR_BYTE;
                  else if (bus_state_reg == lowspeed_pkg::BUS_ADDR_ACK
                           || bit_cnt_reg == 4'h1)
                  begin
                     bus_state_next = lowspeed_pkg::BUS_RD_BYTE;
                     rd_load        = 1'b1;
                     shreg_next     = rd_byte;
                     sda_oe_next    = !rd_byte[7];
                     ptr_next       = ptr_reg + 2'h1;
                  end
               end
            end
            lowspeed_pkg::BUS_RD_BYTE:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_reg == 4'h7)
                  begin
                     bus_state_next = lowspeed_pkg::BUS_RD_ACK;
                     sda_oe_next    = 1'b0;
                     bit_cnt_next   = 4'h0;
                  end
                  else
                  begin
                     shreg_next   = {shreg_reg[6:0], 1'b0};
                     sda_oe_next  = !shreg_reg[6];
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
               end
            end
            default: bus_state_next = lowspeed_pkg::BUS_IDLE;
         endcase
      end
      // reading the flags clears only what was read; a new event still sets
      clr_mask   = (rd_load && ptr_reg == lowspeed_pkg::REG_FLAGS) ? flags_reg : 2'b00;
      flags_next = soft_rst ? 2'b00 : (flags_reg & ~clr_mask);
      flags_next.init_done = flags_next.init_done | init_done_evt;
      flags_next.fault     = flags_next.fault | fault_event;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         bus_state_reg <= lowspeed_pkg::BUS_IDLE;
         bit_cnt_reg   <= 4'h0;
         shreg_reg     <= 8'h00;
         ctrl_reg      <= lowspeed_pkg::CONTROL_RESET;
         ptr_reg       <= 2'h0;
         have_ptr_reg  <= 1'b0;
         is_read_reg   <= 1'b0;
         sda_oe_reg    <= 1'b0;
         scl_q_reg     <= 1'b1;
         sda_q_reg     <= 1'b1;
         flags_reg     <= 2'b00;
         power_cap_reg <= 1'b1;
         irq_oe_reg    <= 1'b0;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         bit_cnt_reg   <= bit_cnt_next;
         shreg_reg     <= shreg_next;
         ctrl_reg      <= ctrl_next;
         ptr_reg       <= ptr_next;
         have_ptr_reg  <= have_ptr_next;
         is_read_reg   <= is_read_next;
         sda_oe_reg    <= sda_oe_next;
         scl_q_reg     <= scl_in;
         sda_q_reg     <= sda_in;
         flags_reg     <= flags_next;
         power_cap_reg <= low_power_select | ctrl_reg[lowspeed_pkg::CTRL_LPM_BIT];
         irq_oe_reg    <= |flags_reg;
      end
   end

   assign sda_out               = 1'b0;
   assign sda_oe                = sda_oe_reg;
   assign power_cap             = power_cap_reg;
   assign presence_detect_n_out = 1'b0;
   assign presence_detect_n_oe  = 1'b1;
   assign attention_irq_n_out   = 1'b0;
   assign attention_irq_n_oe    = irq_oe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_unsel_silent: assert property (module_select_n |=> !sda_oe)
      else $error("sda driven while deselected");
   a_soft_defaults: assert property
      (soft_rst |=> (ctrl_reg == lowspeed_pkg::CONTROL_RESET && data_not_ready))
      else $error("module reset did not restore defaults");
   a_done_irq: assert property
      (init_done_evt |=> (!data_not_ready && flags_reg.init_done) ##1 attention_irq_n_oe)
      else $error("completion not posted");
   a_powerup_irq: assert property
      ($fell(reset) |-> ##[1:260] (attention_irq_n_oe || !module_reset_n))
      else $error("no completion interrupt after power-up");
   a_lowpower_cap: assert property (low_power_select |=> power_cap)
      else $error("power not capped in low-power mode");
   a_presence_low: assert property (presence_detect_n_oe && !presence_detect_n_out)
      else $error("presence not pulled low");
   a_fault_irq: assert property (fault_event |-> ##2 attention_irq_n_oe)
      else $error("fault did not raise interrupt");
   a_open_collector: assert property (!attention_irq_n_out)
      else $error("interrupt drives high");
   a_dnr_hold: assert property ($rose(data_not_ready) |-> data_not_ready[*8])
      else $error("data-not-ready dropped early");

   c_init_done: cover property (init_done_evt);
   c_flags_read: cover property (rd_load && ptr_reg == lowspeed_pkg::REG_FLAGS);
   c_ctrl_write: cover property (ctrl_reg != ctrl_next && !soft_rst);

endmodule : lowspeed_ctrl

// ===== verification/host_bus_master.sv
// host board model: 2-wire serial master behind pull-ups
`timescale 1ns/1ps

module host_bus_master
(
   // clock
   input  wire logic clk_sys,
   // resolved serial data level
   input  wire logic sda_wire,
   // host drives of the serial bus
   output logic      scl_drive,
   output logic      sda_low
);

   initial
   begin
      scl_drive = 1'b1;
      sda_low   = 1'b0;
   end

   task automatic half_bit();
      repeat (4) @(negedge clk_sys);
   endtask : half_bit

   task automatic start_cond();
      sda_low = 1'b0;
      half_bit();
      scl_drive = 1'b1;
      half_bit();
      sda_low = 1'b1;
      half_bit();
      scl_drive = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      sda_low = 1'b1;
      half_bit();
      scl_drive = 1'b1;
      half_bit();
      sda_low = 1'b0;
      half_bit();
   endtask : stop_cond

   // data changes only while the clock is low
   task automatic send_bit(input logic b, output logic got);
      sda_low = ~b;
      half_bit();
      scl_drive = 1'b1;
      half_bit();
      got = sda_wire;
      scl_drive = 1'b0;
   endtask : send_bit

   task automatic send_byte(input logic [7:0] data, output logic ack);
      logic unused;
      for (int i = 7; i >= 0; i--)
         send_bit(data[i], unused);
      send_bit(1'b1, unused);
      ack = ~unused;
   endtask : send_byte

   // last byte answered with a release, which ends the read
   task automatic recv_byte(input logic last, output logic [7:0] data);
      logic unused;
      for (int i = 7; i >= 0; i--)
         send_bit(1'b1, data[i]);
      send_bit(last, unused);
   endtask : recv_byte

   task automatic write_reg(input logic [1:0] idx, input logic [7:0] val, output logic ack);
      logic a1;
      logic a2;
      start_cond();
      send_byte({lowspeed_pkg::DEV_ADDR, 1'b0}, ack);
      send_byte({6'h00, idx}, a1);
      send_byte(val, a2);
      stop_cond();
      ack = ack & a1 & a2;
   endtask : write_reg

   // flags are fetched over the bus to learn an interrupt's cause
   task automatic read_reg(input logic [1:0] idx, output logic [7:0] val, output logic ack);
      logic a1;
      logic a2;
      start_cond();
      send_byte({lowspeed_pkg::DEV_ADDR, 1'b0}, ack);
      send_byte({6'h00, idx}, a1);
      start_cond();
      send_byte({lowspeed_pkg::DEV_ADDR, 1'b1}, a2);
      recv_byte(1'b1, val);
      stop_cond();
      ack = ack & a1 & a2;
   endtask : read_reg

endmodule : host_bus_master

// ===== verification/tb_lowspeed_ctrl.sv
// self-checking bench for the low-speed control block
`timescale 1ns/1ps

module tb_lowspeed_ctrl;

   // starts low so no false falling edge appears at time zero
   logic       clk_sys = 1'b0;
   logic       reset, module_select_n, module_reset_n, low_power_select;
   logic       fault_event, scl_drive, sda_low, sda_wire, irq_wire, prs_wire;
   logic       sda_out, sda_oe, presence_detect_n_out, presence_detect_n_oe;
   logic       attention_irq_n_out, attention_irq_n_oe, power_cap, data_not_ready;
   logic       ack, ctrl_bit;
   logic [7:0] rd;
   int         bad_count, checks;

   // open-drain lines resolved against host pull-ups
   assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
   assign irq_wire = ~(attention_irq_n_oe & ~attention_irq_n_out);
   assign prs_wire = ~(presence_detect_n_oe & ~presence_detect_n_out);

   lowspeed_ctrl i_lowspeed_ctrl
   (
      .clk_sys(clk_sys), .reset(reset), .module_select_n(module_select_n),
      .module_reset_n(module_reset_n), .low_power_select(low_power_select),
      .scl_in(scl_drive), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .presence_detect_n_out(presence_detect_n_out),
      .presence_detect_n_oe(presence_detect_n_oe),
      .attention_irq_n_out(attention_irq_n_out), .attention_irq_n_oe(attention_irq_n_oe),
      .fault_event(fault_event), .power_cap(power_cap), .data_not_ready(data_not_ready)
   );

   host_bus_master i_host_bus_master
   (
      .clk_sys(clk_sys), .sda_wire(sda_wire), .scl_drive(scl_drive), .sda_low(sda_low)
   );

   function automatic logic exp_cap(input logic lps, input logic ctrl);
      return lps | ctrl;
   endfunction : exp_cap

   function automatic logic [7:0] exp_status(input logic dnr, input logic cap);
      return {6'h00, cap, dnr};
   endfunction : exp_status

   task automatic tally_and_finish();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // bounded wait for the end of initialization
   task automatic wait_ready();
      int n;
      n = 0;
      while (data_not_ready !== 1'b0 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 400)
      begin
         bad_count++;
         tally_and_finish();
      end
      @(negedge clk_sys);
      @(negedge clk_sys);
   endtask : wait_ready

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      reset            = 1'b1;
      module_select_n  = 1'b1;
      module_reset_n   = 1'b1;
      low_power_select = 1'b0;
      fault_event      = 1'b0;
      bad_count        = 0;
      checks           = 0;
      void'($urandom(3179));
      repeat (4) @(negedge clk_sys);
      check(power_cap, 1'b1);
      check(data_not_ready, 1'b1);
      check(prs_wire, 1'b0);
      reset = 1'b0;
      @(negedge clk_sys);
      check(data_not_ready, 1'b1);
      check(irq_wire, 1'b1);
      wait_ready();
      check(irq_wire, 1'b0);
      // deselected module stays silent
      i_host_bus_master.read_reg(lowspeed_pkg::REG_FLAGS, rd, ack);
      check(ack, 1'b0);
      check(irq_wire, 1'b0);
      module_select_n = 1'b0;
      i_host_bus_master.start_cond();
      i_host_bus_master.send_byte({7'h51, 1'b0}, ack);
      i_host_bus_master.stop_cond();
      check(ack, 1'b0);
      i_host_bus_master.read_reg(lowspeed_pkg::REG_FLAGS, rd, ack);
      check(ack, 1'b1);
      check(rd[0], 1'b1);
      i_host_bus_master.read_reg(lowspeed_pkg::REG_STATUS, rd, ack);
      check(rd, exp_status(1'b0, 1'b0));
      check(irq_wire, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         low_power_select = 1'($urandom);
         ctrl_bit = 1'($urandom);
         if (i == 5)
            ctrl_bit = 1'b1;
         if (i == 5)
            low_power_select = 1'b0;
         i_host_bus_master.write_reg(lowspeed_pkg::REG_CONTROL, {7'h00, ctrl_bit}, ack);
         repeat (3) @(negedge clk_sys);
         check(power_cap, exp_cap(low_power_select, ctrl_bit));
         i_host_bus_master.read_reg(lowspeed_pkg::REG_STATUS, rd, ack);
         check(rd, exp_status(1'b0, exp_cap(low_power_select, ctrl_bit)));
      end
      // identity write is acked but ignored; two-byte read runs on past control
      i_host_bus_master.write_reg(lowspeed_pkg::REG_IDENT, ~lowspeed_pkg::IDENT_VALUE, ack);
      check(ack, 1'b1);
      i_host_bus_master.start_cond();
      i_host_bus_master.send_byte({lowspeed_pkg::DEV_ADDR, 1'b0}, ack);
      i_host_bus_master.send_byte({6'h00, lowspeed_pkg::REG_CONTROL}, ack);
      i_host_bus_master.start_cond();
      i_host_bus_master.send_byte({lowspeed_pkg::DEV_ADDR, 1'b1}, ack);
      check(ack, 1'b1);
      i_host_bus_master.recv_byte(1'b0, rd);
      check(rd, {7'h00, ctrl_bit});
      i_host_bus_master.recv_byte(1'b1, rd);
      i_host_bus_master.stop_cond();
      check(rd, lowspeed_pkg::IDENT_VALUE);
      // fault flag raises the interrupt until the flags are read
      fault_event = 1'b1;
      @(negedge clk_sys);
      fault_event = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(irq_wire, 1'b0);
      i_host_bus_master.read_reg(lowspeed_pkg::REG_FLAGS, rd, ack);
      check(rd[1], 1'b1);
      check(irq_wire, 1'b1);
      // a pulse shorter than the minimum is ignored
      module_reset_n = 1'b0;
      repeat (120) @(negedge clk_sys);
      module_reset_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(data_not_ready, 1'b0);
      check(power_cap, 1'b1);
      module_reset_n = 1'b0;
      repeat (130) @(negedge clk_sys);
      check(data_not_ready, 1'b1);
      check(power_cap, 1'b0);
      check(irq_wire, 1'b1);
      module_reset_n = 1'b1;
      repeat (100) @(negedge clk_sys);
      check(data_not_ready, 1'b1);
      wait_ready();
      check(irq_wire, 1'b0);
      i_host_bus_master.read_reg(lowspeed_pkg::REG_STATUS, rd, ack);
      check(rd, exp_status(1'b0, 1'b0));
      tally_and_finish();
   end

endmodule : tb_lowspeed_ctrl
